/* csf_cfg.svh */
// Constants for the CPU status flag and core register block.
// Assumes a 32-bit AXI4-Lite master; offsets are byte addresses.
//
// Functional notes
// - Write to counter low byte jumps within page
// - Counter low byte jump inserts one idle cycle
// - Table pointers address reads; high byte kept
// - Status writes leave timeout and powerdown alone
// - Carry on add carry, no borrow, rotates
// - Half carry from low nibble, no borrow
// - Zero flag set on all-zero arithmetic or logic result
// - Overflow when carry in and out differ
// - Powerdown: cleared by reset, clear, set halt
// - Timeout: cleared reset, clear, halt; set timeout
// - Signed compare is overflow xor result msb
// - Status never saved automatically on calls
// - Status bit layout; timeout, powerdown read-only
// - Accumulator takes every ALU result
// - Extended address upper part selects sector
// - Chained zero: sub copies, borrow-sub ands
// - Other instructions leave chained zero alone
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
`define CSF_OFS_FLAG    8'h00
`define CSF_OFS_ACC     8'h04
`define CSF_OFS_PCL     8'h08
`define CSF_OFS_PCH     8'h0c
`define CSF_OFS_TABLE_POINTER_LOW    8'h10
`define CSF_OFS_TABLE_POINTER_HIGH    8'h14
`define CSF_OFS_TABLE_READ_HIGH_BYTE    8'h18
`define CSF_OFS_EXT     8'h1c
`define CSF_OFS_IRQST   8'h20
`define CSF_OFS_IRQMSK  8'h24
`define CSF_BIT_C       0
`define CSF_BIT_AC      1
`define CSF_BIT_Z       2
`define CSF_BIT_OV      3
`define CSF_BIT_PDF     4
`define CSF_BIT_TO      5
`define CSF_BIT_CZ      6
`define CSF_BIT_SC      7
`define CSF_FLAG_RST    8'h00
`define CSF_FLAG_WMASK  8'hcf
`define CSF_IRQ_TIMEOUT 0
`define CSF_IRQ_HALT    1
`define CSF_IRQ_JUMP    2
`define CSF_IRQ_TABLE   3
`define CSF_IDLE_CYCLES 1
`endif

/* csf_pkg.sv */
// Types shared by the CPU status flag block.
// Assumes csf_cfg.svh supplies the numeric constants.
package csf_pkg;
  typedef enum logic [3:0] {
    CSF_OP_NOP,
    CSF_OP_ADD,
    CSF_OP_ADC,
    CSF_OP_SUB,
    CSF_OP_SBC,
    CSF_OP_AND,
    CSF_OP_OR,
    CSF_OP_XOR,
    CSF_OP_RLC,
    CSF_OP_RRC,
    CSF_OP_MOV,
    CSF_OP_CLRWDT,
    CSF_OP_HALT,
    CSF_OP_TBLRD,
    CSF_OP_WPCL,
    CSF_OP_EXT
  } csf_op_e;
  typedef enum logic [1:0] {
    CSF_RUN,
    CSF_IDLE
  } csf_state_e;
endpackage

/* csf_core_regs.sv */
// CPU status flags, accumulator, counter low byte, table and sector regs.
// Assumes table data answers combinationally to csf table address.
`timescale 1ns/1ns
`default_nettype none
`include "csf_cfg.svh"
module csf_core_regs
  import csf_pkg::*;
#(
  parameter int PC_W  = 13,
  parameter int EXT_W = 9
) (
  input  wire logic             core_clk,      // 10 MHz clock
  input  wire logic             arst_n,        // Async reset
  input  wire logic [7:0]       s_axi_awaddr,  // Write address
  input  wire logic             s_axi_awvalid, // Write address valid
  output logic                  s_axi_awready, // Write address ready
  input  wire logic [31:0]      s_axi_wdata,   // Write data
  input  wire logic [3:0]       s_axi_wstrb,   // Byte enables
  input  wire logic             s_axi_wvalid,  // Write data valid
  output logic                  s_axi_wready,  // Write data ready
  output logic [1:0]            s_axi_bresp,   // Write response
  output logic                  s_axi_bvalid,  // Response valid
  input  wire logic             s_axi_bready,  // Response ready
  input  wire logic [7:0]       s_axi_araddr,  // Read address
  input  wire logic             s_axi_arvalid, // Read address valid
  output logic                  s_axi_arready, // Read address ready
  output logic [31:0]           s_axi_rdata,   // Read data
  output logic [1:0]            s_axi_rresp,   // Read response
  output logic                  s_axi_rvalid,  // Read valid
  input  wire logic             s_axi_rready,  // Read ready
  input  wire logic             op_valid,      // Instruction strobe
  input  wire logic [3:0]       op_code,       // Instruction kind
  input  wire logic [7:0]       op_operand,    // Data operand
  input  wire logic [EXT_W-1:0] op_ext_addr,   // Full data address
  output logic                  op_ready,      // Low in idle cycle
  input  wire logic             wdt_timeout,   // Watchdog expiry pulse
  output logic [15:0]           table_addr,    // Program memory address
  input  wire logic [15:0]      table_data,    // Program memory word
  output logic [PC_W-1:0]       program_count, // Program counter
  output logic [EXT_W-9:0]      mem_sector,    // Selected sector
  output logic [7:0]            mem_offset,    // Offset in sector
  output logic                  irq            // Interrupt level
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]      cpu_flag_word;
  logic [7:0]      acc;
  logic [7:0]      table_pointer_low;
  logic [7:0]      table_pointer_high;
  logic [7:0]      table_read_high_byte;
  logic [3:0]      irq_status;
  logic [3:0]      irq_mask;
  csf_state_e      state;

  // ----------------------------------------------------------------
  // ALU helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] csf_nib(input logic [3:0] a,
                                         input logic [3:0] b,
                                         input logic       ci);
    csf_nib = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction

  function automatic logic csf_sel(input logic [7:0] a,
                                   input logic [7:0] b);
    csf_sel = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------------------------------
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        ar_go;
  logic        wr_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held && w_held;
  assign ar_go         = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      `CSF_OFS_FLAG, `CSF_OFS_ACC, `CSF_OFS_PCL, `CSF_OFS_PCH,
      `CSF_OFS_TABLE_POINTER_LOW, `CSF_OFS_TABLE_POINTER_HIGH, `CSF_OFS_TABLE_READ_HIGH_BYTE, `CSF_OFS_EXT,
      `CSF_OFS_IRQST, `CSF_OFS_IRQMSK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries register data
  logic       wr_lo;
  logic [7:0] wb;
  assign wr_lo = wr_go && w_strb[0];
  assign wb    = w_data[7:0];

  logic sw_flag;
  logic sw_acc;
  logic sw_pcl;
  logic sw_table_pointer_low;
  logic sw_table_pointer_high;
  logic sw_irqst;
  logic sw_irqmsk;
  assign sw_flag   = wr_lo && csf_sel(aw_addr, `CSF_OFS_FLAG);
  assign sw_acc    = wr_lo && csf_sel(aw_addr, `CSF_OFS_ACC);
  assign sw_pcl    = wr_lo && csf_sel(aw_addr, `CSF_OFS_PCL);
  assign sw_table_pointer_low   = wr_lo && csf_sel(aw_addr, `CSF_OFS_TABLE_POINTER_LOW);
  assign sw_table_pointer_high   = wr_lo && csf_sel(aw_addr, `CSF_OFS_TABLE_POINTER_HIGH);
  assign sw_irqst  = wr_lo && csf_sel(aw_addr, `CSF_OFS_IRQST);
  assign sw_irqmsk = wr_lo && csf_sel(aw_addr, `CSF_OFS_IRQMSK);

  // ----------------------------------------------------------------
  // Instruction execution
  // ----------------------------------------------------------------
  csf_op_e    op;
  logic       run;
  logic [7:0] opb;
  logic       cin;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [4:0] lo7;
  logic [7:0] res;
  logic       arith;
  logic       logic_op;
  logic       c7;
  logic       c8;
  logic       ovf;
  logic       zr;
  logic [7:0] next_flag;
  logic [7:0] next_acc;
  logic       load_acc;

  assign op  = csf_op_e'(op_code);
  assign run = op_valid && op_ready;

  // Subtract is add of inverted operand; carry out means no borrow
  always_comb begin
    arith = 1'b1;
    opb   = op_operand;
    cin   = 1'b0;
    case (op)
      CSF_OP_ADC: cin = cpu_flag_word[`CSF_BIT_C];
      CSF_OP_SUB: begin
        opb = ~op_operand;
        cin = 1'b1;
      end
      CSF_OP_SBC: begin
        opb = ~op_operand;
        cin = cpu_flag_word[`CSF_BIT_C];
      end
      CSF_OP_ADD: cin = 1'b0;
      default: arith = 1'b0;
    endcase
  end

  assign lo_sum = csf_nib(acc[3:0], opb[3:0], cin);
  assign hi_sum = csf_nib(acc[7:4], opb[7:4], lo_sum[4]);
  assign lo7    = csf_nib({1'b0, acc[6:4]}, {1'b0, opb[6:4]}, lo_sum[4]);
  assign c7     = lo7[3];
  assign c8     = hi_sum[4];
  assign ovf    = c7 ^ c8;

  always_comb begin
    logic_op = 1'b1;
    load_acc = 1'b1;
    res      = acc;
    case (op)
      CSF_OP_ADD, CSF_OP_ADC,
      CSF_OP_SUB, CSF_OP_SBC: res = {hi_sum[3:0], lo_sum[3:0]};
      CSF_OP_AND: res = acc & op_operand;
      CSF_OP_OR:  res = acc | op_operand;
      CSF_OP_XOR: res = acc ^ op_operand;
      CSF_OP_RLC: begin
        logic_op = 1'b0;
        res      = {acc[6:0], cpu_flag_word[`CSF_BIT_C]};
      end
      CSF_OP_RRC: begin
        logic_op = 1'b0;
        res      = {cpu_flag_word[`CSF_BIT_C], acc[7:1]};
      end
      CSF_OP_MOV: begin
        logic_op = 1'b0;
        res      = op_operand;
      end
      CSF_OP_TBLRD: begin
        logic_op = 1'b0;
        res      = table_data[7:0];
      end
      default: begin
        logic_op = 1'b0;
        load_acc = 1'b0;
      end
    endcase
  end

  assign zr = (res == 8'h00);

  always_comb begin
    next_flag = cpu_flag_word;
    if (run && arith) begin
      next_flag[`CSF_BIT_C]  = c8;
      next_flag[`CSF_BIT_AC] = lo_sum[4];
      next_flag[`CSF_BIT_OV] = ovf;
      next_flag[`CSF_BIT_SC] = ovf ^ res[7];
    end
    if (run && (arith || logic_op)) begin
      next_flag[`CSF_BIT_Z] = zr;
    end
    if (run && (op == CSF_OP_RLC)) begin
      next_flag[`CSF_BIT_C] = acc[7];
    end
    if (run && (op == CSF_OP_RRC)) begin
      next_flag[`CSF_BIT_C] = acc[0];
    end
    // Other instructions leave chained zero as it was
    if (run && (op == CSF_OP_SUB)) begin
      next_flag[`CSF_BIT_CZ] = zr;
    end
    if (run && (op == CSF_OP_SBC)) begin
      next_flag[`CSF_BIT_CZ] = cpu_flag_word[`CSF_BIT_CZ] & zr;
    end
    // Direct write replaces writable bits outright
    if (sw_flag) begin
      next_flag = (wb & `CSF_FLAG_WMASK) |
                  (cpu_flag_word & ~`CSF_FLAG_WMASK);
    end
    // System flags follow their own events only
    if (run && (op == CSF_OP_CLRWDT)) begin
      next_flag[`CSF_BIT_PDF] = 1'b0;
      next_flag[`CSF_BIT_TO]  = 1'b0;
    end
    if (run && (op == CSF_OP_HALT)) begin
      next_flag[`CSF_BIT_PDF] = 1'b1;
      next_flag[`CSF_BIT_TO]  = 1'b0;
    end
    if (wdt_timeout) begin
      next_flag[`CSF_BIT_TO] = 1'b1;
    end
  end

  // Flags are changed by instructions, bus writes and watchdog timeouts; nothing is stacked on calls
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_flag_word <= `CSF_FLAG_RST;
    end else begin
      cpu_flag_word <= next_flag;
    end
  end

  // Software write wins over an ALU result in the same cycle
  assign next_acc = sw_acc ? wb : res;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 8'h00;
    end else if (sw_acc || (run && load_acc)) begin
      acc <= next_acc;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and idle cycle
  // ----------------------------------------------------------------
  logic       jump;
  logic [7:0] jump_low;

  assign jump     = sw_pcl || (run && (op == CSF_OP_WPCL));
  assign jump_low = sw_pcl ? wb : op_operand;
  assign op_ready = (state == CSF_RUN);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      program_count <= '0;
    end else if (jump) begin
      program_count <= {program_count[PC_W-1:8], jump_low};
    end else if (run) begin
      program_count <= program_count + 1'b1;
    end
  end

  // Jump costs one dead slot while the new target is fetched
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CSF_RUN;
    end else begin
      case (state)
        CSF_RUN:  state <= jump ? CSF_IDLE : CSF_RUN;
        CSF_IDLE: state <= CSF_RUN;
        default:  state <= CSF_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Table pointers and sector address
  // ----------------------------------------------------------------
  assign table_addr = {table_pointer_high, table_pointer_low};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer_low  <= 8'h00;
      table_pointer_high <= 8'h00;
    end else begin
      if (sw_table_pointer_low) begin
        table_pointer_low <= wb;
      end
      if (sw_table_pointer_high) begin
        table_pointer_high <= wb;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_read_high_byte <= 8'h00;
    end else if (run && (op == CSF_OP_TBLRD)) begin
      table_read_high_byte <= table_data[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_sector <= '0;
      mem_offset <= 8'h00;
    end else if (run && (op == CSF_OP_EXT)) begin
      mem_sector <= op_ext_addr[EXT_W-1:8];
      mem_offset <= op_ext_addr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [3:0] irq_event;
  always_comb begin
    irq_event = 4'h0;
    irq_event[`CSF_IRQ_TIMEOUT] = wdt_timeout;
    irq_event[`CSF_IRQ_HALT]    = run && (op == CSF_OP_HALT);
    irq_event[`CSF_IRQ_JUMP]    = jump;
    irq_event[`CSF_IRQ_TABLE]   = run && (op == CSF_OP_TBLRD);
  end

  // New event beats a same-cycle write-one clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (irq_status & ~(sw_irqst ? wb[3:0] : 4'h0)) | irq_event;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= 4'h0;
    end else if (sw_irqmsk) begin
      irq_mask <= wb[3:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CSF_OFS_FLAG:   rd_word[7:0] = cpu_flag_word;
      `CSF_OFS_ACC:    rd_word[7:0] = acc;
      `CSF_OFS_PCL:    rd_word[7:0] = program_count[7:0];
      `CSF_OFS_PCH:    rd_word[PC_W-9:0] = program_count[PC_W-1:8];
      `CSF_OFS_TABLE_POINTER_LOW:   rd_word[7:0] = table_pointer_low;
      `CSF_OFS_TABLE_POINTER_HIGH:   rd_word[7:0] = table_pointer_high;
      `CSF_OFS_TABLE_READ_HIGH_BYTE:   rd_word[7:0] = table_read_high_byte;
      `CSF_OFS_EXT:    rd_word[EXT_W-1:0] = {mem_sector, mem_offset};
      `CSF_OFS_IRQST:  rd_word[3:0] = irq_status;
      `CSF_OFS_IRQMSK: rd_word[3:0] = irq_mask;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* csf_core_regs_assertions.sv */
// Port-level checks for csf_core_regs, bound into every instance.
// Assumes one clock domain and the async active-low reset of the block.
`timescale 1ns/1ns
`default_nettype none
module csf_core_regs_assertions
  import csf_pkg::*;
#(
  parameter int PC_W  = 13,
  parameter int EXT_W = 9
) (
  input wire logic             core_clk,      // Clock
  input wire logic             arst_n,        // Async reset
  input wire logic             s_axi_bvalid,  // Write response valid
  input wire logic             op_valid,      // Instruction strobe
  input wire logic [3:0]       op_code,       // Instruction kind
  input wire logic [7:0]       op_operand,    // Operand
  input wire logic [EXT_W-1:0] op_ext_addr,   // Full data address
  input wire logic             op_ready,      // Idle cycle marker
  input wire logic [15:0]      table_addr,    // Table address
  input wire logic [PC_W-1:0]  program_count, // Counter
  input wire logic [EXT_W-9:0] mem_sector,    // Sector
  input wire logic [7:0]       mem_offset     // Offset
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = op_valid && op_ready;
  a_jump_idle: assert property (take && op_code == CSF_OP_WPCL |=> !op_ready)
    else $error("no idle cycle after jump");
  a_idle_once: assert property (!op_ready |=> op_ready)
    else $error("idle lasted more than one cycle");
  a_jump_page: assert property (take && op_code == CSF_OP_WPCL |=>
    program_count[7:0] == $past(op_operand) &&
    program_count[PC_W-1:8] == $past(program_count[PC_W-1:8]))
    else $error("jump target or page wrong");
  a_pc_step: assert property (take && op_code != CSF_OP_WPCL |=>
    program_count == $past(program_count) + 1'b1 || $rose(s_axi_bvalid))
    else $error("counter moved without a jump");
  a_idle_hold: assert property (!op_ready |=>
    $stable(program_count) || $rose(s_axi_bvalid))
    else $error("instruction ran in idle cycle");
  a_sector_load: assert property (take && op_code == CSF_OP_EXT |=>
    {mem_sector, mem_offset} == $past(op_ext_addr))
    else $error("sector split wrong");
  a_sector_hold: assert property (!(take && op_code == CSF_OP_EXT) |=>
    $stable(mem_sector) && $stable(mem_offset))
    else $error("sector changed without access");
  a_table_ptr: assert property ($changed(table_addr) |-> $rose(s_axi_bvalid))
    else $error("table address changed without write");
  c_jump: cover property (take && op_code == CSF_OP_WPCL);
  c_ext: cover property (take && op_code == CSF_OP_EXT);
  c_table: cover property (take && op_code == CSF_OP_TBLRD);
endmodule
bind csf_core_regs csf_core_regs_assertions #(.PC_W(PC_W), .EXT_W(EXT_W)) chk_u (
  .core_clk, .arst_n, .s_axi_bvalid, .op_valid, .op_code, .op_operand, .op_ext_addr,
  .op_ready, .table_addr, .program_count, .mem_sector, .mem_offset
);
`default_nettype wire

/* cpu_status_flags_core_regs_test.sv */
// Self-checking bench for csf_core_regs over AXI4-Lite and the op port.
// Assumes the package, the design and its checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module cpu_status_flags_core_regs_test
  import csf_pkg::*;
;
  logic        core_clk = 1'b0, arst_n = 1'b0, irq;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_valid = 1'b0;
  logic        wdt_timeout = 1'b0, op_ready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, op_operand = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'h1, op_code = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [8:0]  op_ext_addr = 9'h000;
  logic [15:0] table_addr, table_data = 16'hbeef;
  logic [12:0] program_count;
  logic [0:0]  mem_sector;
  logic [7:0]  mem_offset;
  int          bad_count = 0, n_checks = 0;
  csf_core_regs dut_u (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_code, .op_operand,
    .op_ext_addr, .op_ready, .wdt_timeout, .table_addr, .table_data, .program_count,
    .mem_sector, .mem_offset, .irq
  );
  always #50 core_clk = ~core_clk;
  // ----
  // Bus and port tasks
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge core_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Spare edge so a following call never re-drives in this step
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task op(input csf_op_e c, input logic [7:0] v);
    op_valid <= 1'b1;
    op_code <= c;
    op_operand <= v;
    do @(posedge core_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task tmo;
    wdt_timeout <= 1'b1;
    @(posedge core_clk);
    wdt_timeout <= 1'b0;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    rchk(8'h00, 32'h00);
    rchk(8'h04, 32'h00);
    rd(8'h30);
    chk(rsp, 32'h2);
    wr(8'h30, 32'h55);
    chk(rsp, 32'h2);
    wr(8'h00, 32'hff);
    chk(rsp, 32'h0);
    rchk(8'h00, 32'hcf);
  endtask
  task t_arith;
    wr(8'h00, 32'h00);
    op(CSF_OP_MOV, 8'h7f);
    op(CSF_OP_ADD, 8'h01);
    rchk(8'h04, 32'h80);
    rchk(8'h00, 32'h0a);
    op(CSF_OP_ADD, 8'h80);
    rchk(8'h04, 32'h00);
    rchk(8'h00, 32'h8d);
    op(CSF_OP_MOV, 8'h05);
    op(CSF_OP_SUB, 8'h05);
    rchk(8'h00, 32'h47);
    op(CSF_OP_MOV, 8'h03);
    rchk(8'h00, 32'h47);
    op(CSF_OP_SBC, 8'h01);
    rchk(8'h00, 32'h03);
    op(CSF_OP_SBC, 8'h02);
    rchk(8'h00, 32'h07);
    op(CSF_OP_XOR, 8'hff);
    rchk(8'h04, 32'hff);
    rchk(8'h00, 32'h03);
    wr(8'h00, 32'h00);
    op(CSF_OP_RLC, 8'h00);
    rchk(8'h04, 32'hfe);
    rchk(8'h00, 32'h01);
    op(CSF_OP_RRC, 8'h00);
    rchk(8'h04, 32'hff);
    rchk(8'h00, 32'h00);
    op(CSF_OP_ADC, 8'h01);
    rchk(8'h04, 32'h00);
    rchk(8'h00, 32'h07);
    op(CSF_OP_ADC, 8'h01);
    rchk(8'h04, 32'h02);
    rchk(8'h00, 32'h00);
    op(CSF_OP_AND, 8'h00);
    rchk(8'h00, 32'h04);
    op(CSF_OP_OR, 8'h80);
    rchk(8'h04, 32'h80);
    rchk(8'h00, 32'h00);
  endtask
  task t_sys;
    op(CSF_OP_HALT, 8'h00);
    rchk(8'h00, 32'h10);
    tmo();
    rchk(8'h00, 32'h30);
    wr(8'h00, 32'h00);
    rchk(8'h00, 32'h30);
    op(CSF_OP_CLRWDT, 8'h00);
    rchk(8'h00, 32'h00);
    tmo();
    op(CSF_OP_HALT, 8'h00);
    rchk(8'h00, 32'h10);
  endtask
  task t_irq;
    rchk(8'h20, 32'h03);
    wr(8'h20, 32'h0f);
    wr(8'h24, 32'h01);
    chk(irq, 32'h0);
    tmo();
    @(negedge core_clk);
    chk(irq, 32'h1);
    wr(8'h24, 32'h00);
    chk(irq, 32'h0);
    wr(8'h24, 32'h01);
    chk(irq, 32'h1);
    wr(8'h20, 32'h01);
    chk(irq, 32'h0);
  endtask
  task t_jump;
    op_valid <= 1'b1;
    op_code <= CSF_OP_WPCL;
    op_operand <= 8'h5a;
    @(posedge core_clk);
    op_code <= CSF_OP_NOP;
    @(negedge core_clk);
    chk(op_ready, 32'h0);
    chk(program_count, 32'h5a);
    @(posedge core_clk);
    @(posedge core_clk);
    op_valid <= 1'b0;
    @(negedge core_clk);
    chk(program_count, 32'h5b);
    wr(8'h08, 32'h33);
    rchk(8'h08, 32'h33);
    rchk(8'h0c, 32'h00);
  endtask
  task t_table;
    wr(8'h10, 32'h34);
    wr(8'h14, 32'h12);
    chk(table_addr, 32'h1234);
    op(CSF_OP_TBLRD, 8'h00);
    rchk(8'h18, 32'hbe);
    rchk(8'h04, 32'hef);
    op_ext_addr <= 9'h1f0;
    op(CSF_OP_EXT, 8'h00);
    @(negedge core_clk);
    chk({mem_sector, mem_offset}, 32'h1f0);
    rchk(8'h1c, 32'h1f0);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_arith();
    t_sys();
    t_irq();
    t_jump();
    t_table();
    end_sim();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #500000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
